// ### logic/flash_cmd_pkg.sv
// Opcodes, timing counts, address layout and frame states of the security
// register, deep sleep and identification command unit.
// Assumes a 50 MHz system clock that samples the serial pins.
package flash_cmd_pkg;

  // ==========================================================================
  // Opcodes
  localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_SECREG_PROGRAM  = 8'h42;
  localparam logic [7:0] OP_SECREG_READ     = 8'h48;
  localparam logic [7:0] OP_DEEP_SLEEP      = 8'hB9;
  localparam logic [7:0] OP_SIGNATURE       = 8'hAB;
  localparam logic [7:0] OP_ID_SINGLE       = 8'h90;
  localparam logic [7:0] OP_ID_DUAL         = 8'h92;
  localparam logic [7:0] OP_ID_QUAD         = 8'h94;

  // ==========================================================================
  // Timing
  localparam int CLK_MHZ              = 50;
  localparam int PAGE_PROGRAM_TIME_US = 700;
  localparam int PAGE_PROGRAM_CYCLES  = PAGE_PROGRAM_TIME_US * CLK_MHZ;
  localparam int SLEEP_ENTRY_DELAY_NS = 3000;
  localparam int SLEEP_ENTRY_CYCLES   = (SLEEP_ENTRY_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int SLEEP_EXIT_DELAY_NS  = 8000;
  localparam int SLEEP_EXIT_CYCLES    = SLEEP_EXIT_DELAY_NS * CLK_MHZ / 1000;

  // ==========================================================================
  // Geometry, framing and reset values
  localparam int         SECREG_BYTES    = 512;
  localparam int         SECREG_COUNT    = 3;
  localparam logic [3:0] SECREG_SEL_FIRST = 4'h1;
  localparam logic [3:0] SECREG_SEL_LAST  = 4'h3;
  localparam logic [7:0] ERASED_BYTE     = 8'hFF;
  localparam logic [5:0] ADDR_PHASE_BITS = 6'h18;
  localparam logic [5:0] READ_DUMMY_BITS = 6'h08;
  localparam logic [5:0] QUAD_DUMMY_BITS = 6'h18;
  localparam logic [3:0] OPCODE_CLOCKS   = 4'h8;
  localparam logic       LATCH_RESET     = 1'b0;
  localparam logic       SLEEP_RESET     = 1'b0;
  localparam logic       BUSY_RESET      = 1'b0;

  typedef struct packed {
    logic [7:0] high;
    logic [3:0] sel;
    logic [2:0] pad;
    logic [8:0] offset;
  } secaddr_s;

  typedef enum logic [7:0] {
    ST_OPCODE = 8'h01,
    ST_ADDR   = 8'h02,
    ST_DUMMY  = 8'h04,
    ST_PDATA  = 8'h08,
    ST_RDATA  = 8'h10,
    ST_SIG    = 8'h20,
    ST_IDOUT  = 8'h40,
    ST_IGNORE = 8'h80
  } frame_state_e;

endpackage

// ### logic/secreg_cmd_unit.sv
// Serial command unit: security register program/read, deep sleep entry and
// exit, signature read and manufacturer/device ID reads on 1, 2 or 4 lines.
// Assumes the host drives cs_n and sclk at least four mclk periods per phase.
// Contract
// - Program needs the write latch set earlier; refuse it otherwise.
// - Program frame: opcode, 24-bit address, 1 to 512 bytes, select high.
// - Select rise after valid program starts timed cycle; busy bit high throughout.
// - Any lock bit set makes every program ignored.
// - Address: top byte zero, register 1..3 in bits 15-12, bits 11-9 zero.
// - Read frame: opcode, address, dummy byte, then data on falling edges.
// - Read offset increments per byte and wraps from last byte to zero.
// - Deep sleep starts a fixed delay after select rises on its opcode.
// - Asleep, only the release/signature opcode is accepted.
// - Release acts only if select rises right after eight opcode bits; code also releases after a whole signature byte.
// - Leaving deep sleep takes the exit delay; otherwise standby is immediate.
// - Signature byte repeats while clocked; frame ends only when select rises.
// - Release/signature opcode is ignored during a program cycle.
// - Single ID read: opcode, two dummy bytes, address byte, MSB-first output.
// - Address bit 0 picks the first ID code; codes alternate afterwards.
// - Dual ID read carries address and output on two lines.
// - Quad ID read adds mode field and two dummy bytes on four lines.
`timescale 1ns/100ps
module secreg_cmd_unit
  import flash_cmd_pkg::*;
#(
  parameter int         PROG_CYCLES    = PAGE_PROGRAM_CYCLES,
  parameter logic [7:0] SIGNATURE_CODE = 8'h5A,  // Arbitrary value.
  parameter logic [7:0] MAKER_CODE     = 8'hC3,  // Arbitrary value.
  parameter logic [7:0] PART_CODE      = 8'h3C,  // Arbitrary value.
  parameter int         FIFO_DEPTH     = 2
) (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       cs_n,
  input  wire logic       sclk,
  input  wire logic [3:0] data_line_in,
  input  wire logic [2:0] secreg_lock_bits,
  output logic            busy_cycle_bit,
  output logic            write_latch_bit,
  output logic            deep_sleep_state,
  output logic [3:0]      data_line_out,
  output logic [3:0]      data_line_oe
);

  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  // ==========================================================================
  // Pin synchronisers
  logic [1:0] cs_sync_q, clk_sync_q;
  logic [3:0] din_s1_q, din_s2_q;
  logic       cs_prev_q, clk_prev_q;
  logic       cs_hi, rise_e, fall_e, cs_rise_e;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cs_sync_q  <= 2'h3;
      clk_sync_q <= 2'h0;
      din_s1_q   <= 4'h0;
      din_s2_q   <= 4'h0;
      cs_prev_q  <= 1'b1;
      clk_prev_q <= 1'b0;
    end else begin
      cs_sync_q  <= {cs_sync_q[0], cs_n};
      clk_sync_q <= {clk_sync_q[0], sclk};
      din_s1_q   <= data_line_in;
      din_s2_q   <= din_s1_q;
      cs_prev_q  <= cs_sync_q[1];
      clk_prev_q <= clk_sync_q[1];
    end
  end

  assign cs_hi     = cs_sync_q[1];
  assign rise_e    = clk_sync_q[1] & ~clk_prev_q;
  assign fall_e    = ~clk_sync_q[1] & clk_prev_q;
  assign cs_rise_e = cs_hi & ~cs_prev_q;

  // ==========================================================================
  // Frame state
  frame_state_e            st_q, st_d;
  logic [7:0]              op_q, op_d, obyte_q, obyte_d, load_byte;
  logic [2:0]              lanes_q, lanes_d, bcnt_q, bcnt_d, ocnt_q, ocnt_d;
  logic [5:0]              cnt_q, cnt_d, need_q, need_d, cnt_nx;
  logic [31:0]             sh_q, sh_d, sh_in;
  secaddr_s                addr_q, addr_d, addr_in;
  logic [3:0]              clks_q, clks_d, out_q, out_d, oe_q, oe_d;
  logic [8:0]              poff_q, poff_d, foff_q, foff_d;
  logic                    got_q, got_d, idsel_q, idsel_d, sig_q, sig_d;
  logic [SECREG_BYTES-1:0] mask_q, mask_d;
  logic                    stage_we, addr_ok, fetch_act, push, pop;
  logic [7:0]              stage_q [SECREG_BYTES];
  // The array powers up erased; reset leaves its contents alone, as a real cell would.
  logic [7:0]              mem_q [SECREG_COUNT * SECREG_BYTES] = '{default: ERASED_BYTE};
  logic                    busy_q, latch_q, sleep_q, entry_q, exit_q;

  // ==========================================================================
  // Two-entry prefetch buffer between the array and the read shifter
  logic [7:0]    fifo_q [FIFO_DEPTH];
  logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [CW-1:0] fcnt_q, fcnt_d;
  logic [7:0]    push_data;

  always_comb begin
    case (lanes_q)
      3'h4:    sh_in = {sh_q[27:0], din_s2_q};
      3'h2:    sh_in = {sh_q[29:0], din_s2_q[1:0]};
      default: sh_in = {sh_q[30:0], din_s2_q[0]};
    endcase
  end

  assign addr_in = sh_in[23:0];
  assign cnt_nx  = cnt_q + {3'h0, lanes_q};
  // Register select, top byte and pad bits are all checked.
  assign addr_ok = (addr_q.high == 8'h00) && (addr_q.pad == 3'h0)
                 && (addr_q.sel >= SECREG_SEL_FIRST) && (addr_q.sel <= SECREG_SEL_LAST);
  // Prefetch runs through the dummy byte so the first falling edge finds data.
  assign fetch_act = !cs_hi && (op_q == OP_SECREG_READ) && ((st_q == ST_DUMMY) || (st_q == ST_RDATA));
  assign push_data = addr_ok ? mem_q[{2'(addr_q.sel - SECREG_SEL_FIRST), foff_q}] : ERASED_BYTE;
  assign push      = fetch_act && (fcnt_q != CW'(FIFO_DEPTH));
  assign pop       = fall_e && !cs_hi && (st_q == ST_RDATA) && (ocnt_q == 3'h0) && (fcnt_q != '0);

  always_comb begin
    case (st_q)
      ST_RDATA: load_byte = (fcnt_q != '0) ? fifo_q[rp_q] : ERASED_BYTE;
      ST_SIG:   load_byte = SIGNATURE_CODE;
      default:  load_byte = idsel_q ? PART_CODE : MAKER_CODE;
    endcase
  end

  always_comb begin
    wp_d   = wp_q;
    rp_d   = rp_q;
    fcnt_d = fcnt_q;
    if (cs_hi) begin
      wp_d   = '0;
      rp_d   = '0;
      fcnt_d = '0;
    end else begin
      if (push) wp_d = (wp_q == PW'(FIFO_DEPTH - 1)) ? '0 : wp_q + 1'b1;
      if (pop) rp_d = (rp_q == PW'(FIFO_DEPTH - 1)) ? '0 : rp_q + 1'b1;
      fcnt_d = fcnt_q + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wp_q   <= '0;
      rp_q   <= '0;
      fcnt_q <= '0;
    end else begin
      wp_q   <= wp_d;
      rp_q   <= rp_d;
      fcnt_q <= fcnt_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (push) fifo_q[wp_q] <= push_data;
  end

  // ==========================================================================
  // Command decode and shifting
  always_comb begin
    st_d = st_q; op_d = op_q; lanes_d = lanes_q; cnt_d = cnt_q; need_d = need_q;
    sh_d = sh_q; addr_d = addr_q; clks_d = clks_q; bcnt_d = bcnt_q; got_d = got_q;
    poff_d = poff_q; foff_d = foff_q; obyte_d = obyte_q; ocnt_d = ocnt_q;
    out_d = out_q; oe_d = oe_q; idsel_d = idsel_q; sig_d = sig_q; mask_d = mask_q;
    stage_we = 1'b0;
    if (push) foff_d = foff_q + 9'h001;  // Nine bits wrap from the last byte to zero.
    if (cs_hi) begin
      st_d = ST_OPCODE; lanes_d = 3'h1; cnt_d = '0; clks_d = '0; bcnt_d = '0;
      got_d = 1'b0; ocnt_d = '0; oe_d = 4'h0; sig_d = 1'b0;
    end else begin
      if (rise_e && (clks_q != 4'hF)) clks_d = clks_q + 4'h1;
      case (st_q)
        ST_OPCODE: if (rise_e) begin
          sh_d  = sh_in;
          cnt_d = cnt_nx;
          if (cnt_q == 6'h07) begin
            op_d   = sh_in[7:0];
            cnt_d  = '0;
            need_d = ADDR_PHASE_BITS;
            st_d   = ST_IGNORE;
            if (sleep_q) begin
              // Only the release/signature opcode survives deep sleep.
              if ((sh_in[7:0] == OP_SIGNATURE) && !busy_q) st_d = ST_SIG;
            end else begin
              case (sh_in[7:0])
                OP_SECREG_PROGRAM: begin
                  if (!busy_q) st_d = ST_ADDR;
                  mask_d = '0;
                end
                OP_SECREG_READ: if (!busy_q) st_d = ST_ADDR;
                OP_SIGNATURE:   if (!busy_q) st_d = ST_SIG;
                OP_ID_SINGLE:   st_d = ST_ADDR;
                OP_ID_DUAL: begin
                  st_d    = ST_ADDR;
                  lanes_d = 3'h2;
                end
                OP_ID_QUAD: begin
                  st_d    = ST_ADDR;
                  lanes_d = 3'h4;
                end
                default: st_d = ST_IGNORE;
              endcase
            end
          end
        end
        ST_ADDR: if (rise_e) begin
          sh_d  = sh_in;
          cnt_d = cnt_nx;
          if (cnt_nx == need_q) begin
            addr_d  = addr_in;
            cnt_d   = '0;
            foff_d  = addr_in.offset;
            poff_d  = addr_in.offset;
            idsel_d = addr_in.offset[0];
            case (op_q)
              OP_SECREG_PROGRAM: st_d = ST_PDATA;
              OP_SECREG_READ: begin
                st_d   = ST_DUMMY;
                need_d = READ_DUMMY_BITS;
              end
              OP_ID_QUAD: begin
                st_d   = ST_DUMMY;
                need_d = QUAD_DUMMY_BITS;
              end
              default: st_d = ST_IDOUT;
            endcase
          end
        end
        ST_DUMMY: if (rise_e) begin
          cnt_d = cnt_nx;
          if (cnt_nx == need_q) st_d = (op_q == OP_SECREG_READ) ? ST_RDATA : ST_IDOUT;
        end
        ST_PDATA: if (rise_e) begin
          sh_d   = sh_in;
          bcnt_d = bcnt_q + 3'h1;
          if (bcnt_q == 3'h7) begin
            stage_we = 1'b1;
            mask_d[poff_q] = 1'b1;
            poff_d = poff_q + 9'h001;
            got_d  = 1'b1;
          end
        end
        ST_RDATA, ST_SIG, ST_IDOUT: if (fall_e) begin
          oe_d = (lanes_q == 3'h4) ? 4'hF : (lanes_q == 3'h2) ? 4'h3 : 4'h2;
          if (ocnt_q == 3'h0) begin
            obyte_d = load_byte;
            ocnt_d  = (lanes_q == 3'h4) ? 3'h1 : (lanes_q == 3'h2) ? 3'h3 : 3'h7;
            if (st_q == ST_IDOUT) idsel_d = ~idsel_q;
          end else begin
            obyte_d = obyte_q;
            ocnt_d  = ocnt_q - 3'h1;
            if ((st_q == ST_SIG) && (ocnt_q == 3'h1)) sig_d = 1'b1;
          end
          // Most significant bits leave first on the falling edge.
          case (lanes_q)
            3'h4:    out_d = obyte_d[7:4];
            3'h2:    out_d = {2'h0, obyte_d[7:6]};
            default: out_d = {2'h0, obyte_d[7], 1'b0};
          endcase
          obyte_d = obyte_d << lanes_q;
        end
        ST_IGNORE: st_d = ST_IGNORE;
        default:   st_d = ST_OPCODE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_q <= ST_OPCODE; op_q <= 8'h00; lanes_q <= 3'h1; cnt_q <= '0; need_q <= '0;
      sh_q <= '0; addr_q <= '0; clks_q <= '0; bcnt_q <= '0; got_q <= 1'b0;
      poff_q <= '0; foff_q <= '0; obyte_q <= '0; ocnt_q <= '0; out_q <= 4'h0;
      oe_q <= 4'h0; idsel_q <= 1'b0; sig_q <= 1'b0; mask_q <= '0;
    end else begin
      st_q <= st_d; op_q <= op_d; lanes_q <= lanes_d; cnt_q <= cnt_d; need_q <= need_d;
      sh_q <= sh_d; addr_q <= addr_d; clks_q <= clks_d; bcnt_q <= bcnt_d; got_q <= got_d;
      poff_q <= poff_d; foff_q <= foff_d; obyte_q <= obyte_d; ocnt_q <= ocnt_d; out_q <= out_d;
      oe_q <= oe_d; idsel_q <= idsel_d; sig_q <= sig_d; mask_q <= mask_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (stage_we) stage_q[poff_q] <= sh_in[7:0];
  end

  // ==========================================================================
  // Status: write latch, program cycle, deep sleep
  logic [31:0] pcnt_q, pcnt_d;
  logic [15:0] tcnt_q, tcnt_d;
  logic [1:0]  psel_q, psel_d;
  logic        busy_d, latch_d, sleep_d, entry_d, exit_d, commit, release_ok, mem_we;

  // Commit needs the latch, no lock, a legal address and a whole last byte.
  assign commit = cs_rise_e && (st_q == ST_PDATA) && (op_q == OP_SECREG_PROGRAM) && latch_q
                && !(|secreg_lock_bits) && addr_ok && (bcnt_q == 3'h0) && got_q && !busy_q;
  // Release needs select high right after the opcode or after a whole signature.
  assign release_ok = cs_rise_e && (st_q == ST_SIG) && ((clks_q == OPCODE_CLOCKS) || sig_q);

  always_comb begin
    busy_d = busy_q; latch_d = latch_q; sleep_d = sleep_q; entry_d = entry_q;
    exit_d = exit_q; pcnt_d = pcnt_q; psel_d = psel_q; tcnt_d = tcnt_q;
    if (busy_q) begin
      pcnt_d = pcnt_q + 32'h1;
      if (pcnt_q == 32'(PROG_CYCLES - 1)) busy_d = 1'b0;
    end
    if (cs_rise_e && (op_q == OP_WRITE_LATCH_SET) && (clks_q == OPCODE_CLOCKS) && !busy_q && !sleep_q)
      latch_d = 1'b1;
    if (commit) begin
      busy_d  = 1'b1;
      pcnt_d  = '0;
      psel_d  = 2'(addr_q.sel - SECREG_SEL_FIRST);
      latch_d = 1'b0;
    end
    if (entry_q) begin
      tcnt_d = tcnt_q + 16'h1;
      if (tcnt_q == 16'(SLEEP_ENTRY_CYCLES - 1)) begin
        sleep_d = 1'b1;
        entry_d = 1'b0;
      end
    end
    if (exit_q) begin
      tcnt_d = tcnt_q + 16'h1;
      if (tcnt_q == 16'(SLEEP_EXIT_CYCLES - 1)) begin
        sleep_d = 1'b0;
        exit_d  = 1'b0;
      end
    end
    if (cs_rise_e && (op_q == OP_DEEP_SLEEP) && (clks_q == OPCODE_CLOCKS) && !busy_q && !sleep_q) begin
      entry_d = 1'b1;
      tcnt_d  = '0;
    end
    if (release_ok) begin
      entry_d = 1'b0;  // Not yet asleep, so standby is immediate.
      if (!sleep_q) sleep_d = 1'b0;
      if (sleep_q && !exit_q) begin
        exit_d = 1'b1;
        tcnt_d = '0;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      busy_q <= BUSY_RESET; latch_q <= LATCH_RESET; sleep_q <= SLEEP_RESET;
      entry_q <= 1'b0; exit_q <= 1'b0; pcnt_q <= '0; psel_q <= '0; tcnt_q <= '0;
    end else begin
      busy_q <= busy_d; latch_q <= latch_d; sleep_q <= sleep_d;
      entry_q <= entry_d; exit_q <= exit_d; pcnt_q <= pcnt_d; psel_q <= psel_d; tcnt_q <= tcnt_d;
    end
  end

  // The cycle walks the staged bytes and can only clear bits, as a real cell would.
  assign mem_we = busy_q && (pcnt_q < 32'(SECREG_BYTES)) && mask_q[pcnt_q[8:0]];

  always_ff @(posedge mclk) begin
    if (mem_we) mem_q[{psel_q, pcnt_q[8:0]}] <= mem_q[{psel_q, pcnt_q[8:0]}] & stage_q[pcnt_q[8:0]];
  end

  assign busy_cycle_bit   = busy_q;
  assign write_latch_bit  = latch_q;
  assign deep_sleep_state = sleep_q;
  assign data_line_out    = out_q;
  assign data_line_oe     = oe_q;

  // ==========================================================================
  // Checks
  logic [31:0] hb_q, he_q, hx_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hb_q <= '0; he_q <= '0; hx_q <= '0;
    end else begin
      hb_q <= busy_q ? hb_q + 32'h1 : '0;
      he_q <= entry_q ? he_q + 32'h1 : '0;
      hx_q <= exit_q ? hx_q + 32'h1 : '0;
    end
  end

  a_prog_needs_latch : assert property (@(posedge mclk) disable iff (!resetn)
    $rose(busy_cycle_bit) |-> $past(write_latch_bit) && !write_latch_bit) else $error("program without latch");
  a_prog_busy_len : assert property (@(posedge mclk) disable iff (!resetn)
    $fell(busy_cycle_bit) |-> hb_q == 32'(PROG_CYCLES)) else $error("program cycle length wrong");
  a_prog_lock_ignored : assert property (@(posedge mclk) disable iff (!resetn)
    $rose(busy_cycle_bit) |-> !$past(|secreg_lock_bits)) else $error("locked register programmed");
  a_prog_byte_edge : assert property (@(posedge mclk) disable iff (!resetn)
    $rose(busy_cycle_bit) |-> $past(bcnt_q) == 3'h0 && $past(got_q) && $past(addr_ok)) else $error("bad program frame");
  a_read_offset_wrap : assert property (@(posedge mclk) disable iff (!resetn)
    (push && foff_q == 9'h1FF) |=> foff_q == 9'h000) else $error("read offset did not wrap");
  a_sleep_entry_delay : assert property (@(posedge mclk) disable iff (!resetn)
    $rose(deep_sleep_state) |-> he_q == 32'(SLEEP_ENTRY_CYCLES)) else $error("sleep entered early");
  a_sleep_exit_delay : assert property (@(posedge mclk) disable iff (!resetn)
    $fell(deep_sleep_state) |-> hx_q == 32'(SLEEP_EXIT_CYCLES)) else $error("sleep left at wrong time");
  a_sleep_filters_ops : assert property (@(posedge mclk) disable iff (!resetn)
    ($past(deep_sleep_state) && $past(st_q) == ST_OPCODE && st_q != ST_OPCODE) |-> st_q inside {ST_SIG, ST_IGNORE})
    else $error("command accepted in sleep");
  a_sig_not_busy : assert property (@(posedge mclk) disable iff (!resetn)
    busy_cycle_bit |-> st_q != ST_SIG) else $error("signature served while busy");
  a_id_first_code : assert property (@(posedge mclk) disable iff (!resetn)
    $rose(st_q == ST_IDOUT) |-> idsel_q == addr_q.offset[0]) else $error("wrong first ID code");

endmodule

// ### verif/spi_host_model.sv
// Host controller model that frames commands on cs_n, sclk and the data lines.
// Assumes mode 0 framing, mclk at 50 MHz and sclk at 160 ns per period.
`timescale 1ns/100ps
module spi_host_model (
  input  wire logic       mclk,
  output logic            cs_n,
  output logic            sclk,
  output logic [3:0]      data_line_in,
  input  wire logic [3:0] data_line_out
);
  // ==========================================================================
  // Framing
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    data_line_in = 4'h0;
  end

  task automatic half();
    repeat (4) @(posedge mclk);
  endtask

  task automatic start();
    @(posedge mclk);
    cs_n <= 1'b0;
    half();
  endtask

  // Sends the top nbits of b, most significant bit first.
  task automatic send(input logic [7:0] b, input int nbits);
    for (int i = 7; i > 7 - nbits; i--) begin
      data_line_in <= {4{b[i]}};
      half();
      sclk <= 1'b1;
      half();
      sclk <= 1'b0;
    end
  endtask

  // Samples mid-bit on the falling mclk edge so a late output update cannot race.
  // Takes lanes bits a clock, highest line first: line 1 alone, lines 1:0 or lines 3:0.
  task automatic recv(output logic [7:0] b, input int lanes);
    b = 8'h00;
    for (int i = 0; i < 8 / lanes; i++) begin
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      case (lanes)
        4:       b = {b[3:0], data_line_out};
        2:       b = {b[5:0], data_line_out[1:0]};
        default: b = {b[6:0], data_line_out[1]};
      endcase
      @(posedge mclk);
      sclk <= 1'b1;
      half();
      sclk <= 1'b0;
    end
  endtask

  // The released line shows the inverse of the last bit, never a stale copy.
  task automatic stop();
    half();
    cs_n <= 1'b1;
    data_line_in <= ~data_line_in;
    half();
  endtask
endmodule

// ### verif/testbench.sv
// Self-checking bench for the serial command unit.
// Assumes the host model in its own file and a shortened program cycle.
`timescale 1ns/100ps
module testbench;
  import flash_cmd_pkg::*;
  localparam int         PROG  = 600;
  localparam logic [7:0] SIG   = 8'h5A;
  localparam logic [7:0] MAKER = 8'hC3;
  localparam logic [7:0] PART  = 8'h3C;
  typedef struct {
    logic [7:0]  op;
    int          lanes;
    int          nclk;
    logic [31:0] pre;
    logic [3:0]  oe;
    logic [15:0] exp;
  } row_s;
  logic        mclk, resetn, cs_n, sclk, busy_cycle_bit, write_latch_bit, deep_sleep_state;
  logic [3:0]  data_line_in, data_line_out, data_line_oe;
  logic [2:0]  secreg_lock_bits;
  logic [7:0]  rd0, rd1;
  logic [3:0]  oe_hold;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          oe_cycles = 0;
  int          oe_mark;
  row_s        rows[6] = '{'{8'hAB, 1, 0, 32'h0, 4'h2, {SIG, SIG}}, '{8'h90, 1, 24, 32'h0, 4'h2, {MAKER, PART}},
                           '{8'h90, 1, 24, 32'h1, 4'h2, {PART, MAKER}},
                           '{8'h48, 1, 32, 32'h00100000, 4'h2, 16'hFFFF},
                           '{8'h92, 2, 12, 32'h1, 4'h3, {PART, MAKER}}, '{8'h94, 4, 12, 32'h40, 4'hF, {PART, MAKER}}};

  spi_host_model u_host (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .data_line_in(data_line_in),
                         .data_line_out(data_line_out));
  secreg_cmd_unit #(.PROG_CYCLES(PROG), .SIGNATURE_CODE(SIG), .MAKER_CODE(MAKER), .PART_CODE(PART)) u_dut (
    .mclk(mclk), .resetn(resetn), .cs_n(cs_n), .sclk(sclk), .data_line_in(data_line_in),
    .secreg_lock_bits(secreg_lock_bits), .busy_cycle_bit(busy_cycle_bit), .write_latch_bit(write_latch_bit),
    .deep_sleep_state(deep_sleep_state), .data_line_out(data_line_out), .data_line_oe(data_line_oe));

  // Counts cycles with any output enable high, so a refused frame can be shown to stay silent.
  always @(negedge mclk) if (|data_line_oe) oe_cycles++;

  // ==========================================================================
  // Checking and verdict
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ==========================================================================
  // Command helpers
  task automatic read_two(input logic [7:0] op, input int lanes, input int nclk, input logic [31:0] pre);
    u_host.start();
    u_host.send(op, 8);
    for (int k = nclk - 1; k >= 0; k--) u_host.send({pre[k], 7'h00}, 1);
    u_host.recv(rd0, lanes);
    u_host.recv(rd1, lanes);
    oe_hold = data_line_oe;
    u_host.stop();
  endtask

  task automatic opcode_only(input logic [7:0] op);
    u_host.start();
    u_host.send(op, 8);
    u_host.stop();
  endtask

  // Programs AA at addr and 55 just after it; cut adds three stray bits after the last byte.
  task automatic prog_secreg(input logic write_latch_set_cmd, input logic [2:0] lock, input logic [23:0] addr, input logic cut);
    secreg_lock_bits <= lock;
    if (write_latch_set_cmd) opcode_only(OP_WRITE_LATCH_SET);
    u_host.start();
    u_host.send(OP_SECREG_PROGRAM, 8);
    for (int k = 4; k >= 0; k--) u_host.send(8'({addr, 16'hAA55} >> (8 * k)), 8);
    if (cut) u_host.send(8'h00, 3);
    u_host.stop();
    repeat (10) @(posedge mclk);
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  initial begin
    #1000000;
    miscompares++;
    give_verdict();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    resetn = 1'b0;
    secreg_lock_bits = 3'h0;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    check_flag(busy_cycle_bit, BUSY_RESET);
    foreach (rows[i]) begin
      read_two(rows[i].op, rows[i].lanes, rows[i].nclk, rows[i].pre);
      check_byte(rd0, rows[i].exp[15:8]);
      check_byte(rd1, rows[i].exp[7:0]);
      check_byte({4'h0, oe_hold}, {4'h0, rows[i].oe});
    end
    prog_secreg(1'b0, 3'h0, 24'h0011FF, 1'b0);
    check_flag(busy_cycle_bit, 1'b0);
    prog_secreg(1'b1, 3'h4, 24'h0011FF, 1'b0);
    check_flag(busy_cycle_bit, 1'b0);
    check_flag(write_latch_bit, 1'b1);
    prog_secreg(1'b1, 3'h0, 24'h0011FF, 1'b1);
    check_flag(busy_cycle_bit, 1'b0);
    prog_secreg(1'b1, 3'h0, 24'h0041FF, 1'b0);
    check_flag(busy_cycle_bit, 1'b0);
    prog_secreg(1'b1, 3'h0, 24'h0011FF, 1'b0);
    check_flag(busy_cycle_bit, 1'b1);
    check_flag(write_latch_bit, 1'b0);
    oe_mark = oe_cycles;
    read_two(OP_SIGNATURE, 1, 0, 32'h0);
    check_flag(oe_cycles != oe_mark, 1'b0);
    check_flag(busy_cycle_bit, 1'b1);
    for (int w = 0; w < PROG + 50 && busy_cycle_bit; w++) @(posedge mclk);
    check_flag(busy_cycle_bit, 1'b0);
    read_two(OP_SECREG_READ, 1, 32, 32'h0011FF00);
    check_byte(rd0, 8'hAA);
    check_byte(rd1, 8'h55);
    opcode_only(OP_DEEP_SLEEP);
    check_flag(deep_sleep_state, 1'b0);
    repeat (160) @(posedge mclk);
    check_flag(deep_sleep_state, 1'b1);
    oe_mark = oe_cycles;
    read_two(OP_ID_SINGLE, 1, 24, 32'h0);
    check_flag(oe_cycles != oe_mark, 1'b0);
    u_host.start();
    u_host.send(OP_SIGNATURE, 8);
    u_host.send(8'h00, 1);
    u_host.stop();
    repeat (450) @(posedge mclk);
    check_flag(deep_sleep_state, 1'b1);
    opcode_only(OP_SIGNATURE);
    repeat (390) @(posedge mclk);
    check_flag(deep_sleep_state, 1'b1);
    repeat (30) @(posedge mclk);
    check_flag(deep_sleep_state, 1'b0);
    opcode_only(OP_WRITE_LATCH_SET);
    repeat (5) @(posedge mclk);
    check_flag(write_latch_bit, 1'b1);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    check_flag(write_latch_bit, LATCH_RESET);
    give_verdict();
  end
endmodule
